// [rtl/self_program_flash_defs.svh]
// Offsets, field positions, reset values and timing counts of the self-program flash control.
// Included by the package and the module; definitions only.
`ifndef SELF_PROGRAM_FLASH_DEFS_SVH
`define SELF_PROGRAM_FLASH_DEFS_SVH

// Wishbone byte offsets, one 32-bit word each
`define REG_CTRL_STATUS   8'h00
`define REG_POINTER       8'h04
`define REG_PAGE_EXT      8'h08
`define REG_STORE_DATA    8'h0C
`define REG_ISSUE         8'h10
`define REG_LOAD_RESULT   8'h14
`define REG_ENGINE_STATE  8'h18

// Control/status field positions
`define BIT_IRQ_ENABLE    7
`define BIT_SECTION_BUSY  6
`define BIT_REENABLE      4
`define BIT_LOCK_SET      3
`define BIT_PAGE_WRITE    2
`define BIT_PAGE_ERASE    1
`define BIT_STORE_ARM     0

// Issue register bits
`define BIT_ISSUE_STORE   0
`define BIT_ISSUE_LOAD    1

// Accepted lower-five-bit command patterns
`define CMD_REENABLE      5'h11
`define CMD_LOCK_SET      5'h09
`define CMD_PAGE_WRITE    5'h05
`define CMD_PAGE_ERASE    5'h03
`define CMD_BUFFER_LOAD   5'h01

// Reset values
`define CTRL_RESET        8'h00
`define LOCK_RESET        8'hFF
`define APP_RESET_VECTOR  16'h0000

// Windows in CPU clock cycles
`define STORE_WINDOW      3'h4
`define LOAD_WINDOW       3'h3

// Timing
`define CLK_PERIOD_NS     8
`define PROG_TIME_NS      4500000

`endif

// [rtl/self_program_flash_pkg.sv]
// Types shared by the self-program flash control.
// Expects the defs header on the include path.
`include "self_program_flash_defs.svh"

package self_program_flash_pkg;

  // Programming engine activity
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_WRITE
  } op_e;

  // True for the five command patterns that take effect
  function automatic logic cmd_valid(input logic [4:0] c);
    cmd_valid = (c == `CMD_REENABLE)   || (c == `CMD_LOCK_SET)    ||
                (c == `CMD_PAGE_WRITE) || (c == `CMD_PAGE_ERASE)  ||
                (c == `CMD_BUFFER_LOAD);
  endfunction

endpackage

// [rtl/self_program_flash_control.sv]
// Self-programming control for the on-chip program flash: control/status register,
// arming window, page buffer, erase/write engine, lock bits and reset vector select.
// Assumes a Wishbone classic master standing in for the CPU core, fuses as static
// inputs and a flash array that takes one erase pulse or one word per write strobe.
// Function
// - Reset vector from boot-reset fuse value
// - No path lets software change fuses
// - Ready interrupt while enabled, global, not armed
// - Busy flag set on concurrent-section erase/write
// - Busy clears by re-enable or buffer-load store
// - Re-enable ignored while operation still running
// - Re-enable write discards loaded buffer data
// - Lock-set store programs lock bits from R0
// - Armed lock-set load returns lock or fuse
// - Page-write store writes buffer to page
// - Page-erase store erases pointer-selected page
// - Halt CPU for halting-section erase/write
// - Plain store puts R1:R0 into buffer
// - Store arm lasts four cycles, holds during operation
// - Only five command patterns take effect
// - Target address latched at operation start
// - Pointer plus extension: word and page fields
// - Loads address flash bytewise using Z0
// - Buffer words writable in any order
// - Buffer clears after write, re-enable, reset
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "self_program_flash_defs.svh"

module self_program_flash_control #(
  parameter int          PAGE_WORDS      = 128,
  parameter int          PAGE_BITS       = 9,
  parameter int          HALTING_SECTION_FIRST_PAGE = 480,
  parameter logic [15:0] BOOT_START      = 16'hF000,
  parameter int          PROG_CYCLES     = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic                                           clk_i,
  input  wire logic                                           rst_i,
  input  wire logic                                           wb_cyc_i,
  input  wire logic                                           wb_stb_i,
  input  wire logic                                           wb_we_i,
  input  wire logic [7:0]                                     wb_adr_i,
  input  wire logic [3:0]                                     wb_sel_i,
  input  wire logic [31:0]                                    wb_dat_i,
  output logic      [31:0]                                    wb_dat_o,
  output logic                                                wb_ack_o,
  input  wire logic                                           global_irq_enable_i,
  input  wire logic                                           boot_reset_fuse_i,
  input  wire logic [7:0]                                     fuse_low_i,
  input  wire logic [7:0]                                     fuse_high_i,
  input  wire logic [7:0]                                     fuse_ext_i,
  input  wire logic [7:0]                                     flash_rdata_i,
  output logic      [PAGE_BITS+$clog2(PAGE_WORDS):0]          flash_raddr_o,
  output logic                                                flash_erase_o,
  output logic                                                flash_we_o,
  output logic      [PAGE_BITS+$clog2(PAGE_WORDS)-1:0]        flash_waddr_o,
  output logic      [15:0]                                    flash_wdata_o,
  output logic      [7:0]                                     lock_bits_o,
  output logic                                                section_busy_flag_o,
  output logic                                                cpu_halt_o,
  output logic                                                store_ready_irq_o,
  output logic      [15:0]                                    reset_vector_o
);
  import self_program_flash_pkg::*;

  localparam int WORD_BITS = $clog2(PAGE_WORDS);
  localparam int WADDR_W   = PAGE_BITS + WORD_BITS;
  localparam int BADDR_W   = WADDR_W + 1;
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);
  localparam logic [PAGE_BITS-1:0] HALTING_SECTION_PAGE = PAGE_BITS'(HALTING_SECTION_FIRST_PAGE);
  localparam logic [WORD_BITS-1:0] LAST_WORD = WORD_BITS'(PAGE_WORDS - 1);

  typedef struct packed {
    logic                            ack;
    logic [31:0]                     rdat;
    logic                            ie;
    logic                            busy;
    logic [4:0]                      cmd;
    logic [2:0]                      cnt;
    logic [15:0]                     zptr;
    logic [7:0]                      ext;
    logic [15:0]                     wdata;
    logic [7:0]                      result;
    logic [7:0]                      lock;
    logic [PAGE_WORDS-1:0][15:0]     pbuf;
    op_e                             op;
    logic [31:0]                     timer;
    logic                            strm;
    logic [WORD_BITS-1:0]            idx;
    logic [PAGE_BITS-1:0]            page;
    logic                            rd_pend;
    logic                            erase_p;
    logic                            we;
    logic [WADDR_W-1:0]              faddr;
    logic [15:0]                     fwdata;
    logic [BADDR_W-1:0]              raddr;
    logic                            halt;
    logic                            irq;
    logic [15:0]                     rvec;
  } state_s;

  state_s state_ff;
  state_s nxt_state;

  logic                 req;
  logic [23:0]          full_addr;
  logic [BADDR_W-1:0]   byte_addr;
  logic [PAGE_BITS-1:0] tgt_page;
  logic [WORD_BITS-1:0] tgt_word;
  logic                 store_ok;
  logic                 ctrl_wr;

  // Pointer and extension form one byte address; the page and word fields split it
  assign full_addr = {state_ff.ext, state_ff.zptr};
  assign byte_addr = full_addr[BADDR_W-1:0];
  assign tgt_page  = byte_addr[BADDR_W-1:WORD_BITS+1];
  assign tgt_word  = byte_addr[WORD_BITS:1];
  assign req       = wb_cyc_i & wb_stb_i & ~state_ff.ack;
  assign ctrl_wr   = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `REG_CTRL_STATUS);
  // Store only while armed, inside the window and with the engine free
  assign store_ok  = state_ff.cmd[`BIT_STORE_ARM] & (state_ff.cnt != 3'h0) &
                     (state_ff.op == OP_IDLE);

  // Whole next state: bus slave, arming window, command issue and programming engine
  always_comb begin
    nxt_state         = state_ff;
    nxt_state.ack     = 1'b0;
    nxt_state.erase_p = 1'b0;
    nxt_state.we      = 1'b0;
    nxt_state.rd_pend = 1'b0;

    // Window countdown; an unused arm lapses with all its select bits
    if (state_ff.op == OP_IDLE && state_ff.cmd[`BIT_STORE_ARM]) begin
      if (state_ff.cnt <= 3'h1) begin
        nxt_state.cmd = 5'h00;
        nxt_state.cnt = 3'h0;
      end else begin
        nxt_state.cnt = state_ff.cnt - 3'h1;
      end
    end

    // A flash read issued last cycle returns its byte now
    if (state_ff.rd_pend) begin
      nxt_state.result = flash_rdata_i;
    end

    // Engine: erase runs on the timer; write streams the buffer then waits the timer out
    if (state_ff.op != OP_IDLE) begin
      if (state_ff.strm) begin
        nxt_state.we     = 1'b1;
        nxt_state.faddr  = {state_ff.page, state_ff.idx};
        nxt_state.fwdata = state_ff.pbuf[state_ff.idx];
        nxt_state.idx    = state_ff.idx + 1'b1;
        if (state_ff.idx == LAST_WORD) begin
          nxt_state.strm = 1'b0;
        end
      end
      if (state_ff.timer == 32'h0) begin
        // Arm and select bits stay up until here, then release the CPU
        nxt_state.op   = OP_IDLE;
        nxt_state.cmd  = 5'h00;
        nxt_state.halt = 1'b0;
        if (state_ff.op == OP_WRITE) begin
          nxt_state.pbuf = '0;
        end
      end else begin
        nxt_state.timer = state_ff.timer - 32'h1;
      end
    end

    // Bus slave: every access, mapped or not, is answered one cycle later
    if (req) begin
      nxt_state.ack  = 1'b1;
      nxt_state.rdat = 32'h0;
      if (wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL_STATUS: begin
            if (ctrl_wr) begin
              nxt_state.ie = wb_dat_i[`BIT_IRQ_ENABLE];
              // New commands only while the engine is free and the pattern is legal
              if (state_ff.op == OP_IDLE && cmd_valid(wb_dat_i[4:0])) begin
                nxt_state.cmd = wb_dat_i[4:0];
                nxt_state.cnt = `STORE_WINDOW;
                if (wb_dat_i[4:0] == `CMD_REENABLE) begin
                  nxt_state.pbuf = '0;
                end
              end
            end
          end
          `REG_POINTER: begin
            if (wb_sel_i[0]) nxt_state.zptr[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) nxt_state.zptr[15:8] = wb_dat_i[15:8];
          end
          `REG_PAGE_EXT: begin
            if (wb_sel_i[0]) nxt_state.ext = wb_dat_i[7:0];
          end
          `REG_STORE_DATA: begin
            if (wb_sel_i[0]) nxt_state.wdata[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) nxt_state.wdata[15:8] = wb_dat_i[15:8];
          end
          `REG_ISSUE: begin
            if (wb_sel_i[0] && wb_dat_i[`BIT_ISSUE_STORE]) begin
              if (store_ok) begin
                case (state_ff.cmd)
                  `CMD_BUFFER_LOAD: begin
                    nxt_state.pbuf[tgt_word] = state_ff.wdata;
                    nxt_state.busy = 1'b0;
                    nxt_state.cmd  = 5'h00;
                    nxt_state.cnt  = 3'h0;
                  end
                  `CMD_PAGE_ERASE, `CMD_PAGE_WRITE: begin
                    nxt_state.op      = (state_ff.cmd == `CMD_PAGE_ERASE) ? OP_ERASE : OP_WRITE;
                    nxt_state.page    = tgt_page;
                    nxt_state.timer   = PROG_LAST;
                    nxt_state.cnt     = 3'h0;
                    nxt_state.erase_p = (state_ff.cmd == `CMD_PAGE_ERASE);
                    nxt_state.faddr   = {tgt_page, {WORD_BITS{1'b0}}};
                    nxt_state.strm    = (state_ff.cmd == `CMD_PAGE_WRITE);
                    nxt_state.idx     = '0;
                    if (tgt_page >= HALTING_SECTION_PAGE) begin
                      nxt_state.halt = 1'b1;
                    end else begin
                      nxt_state.busy = 1'b1;
                    end
                  end
                  `CMD_LOCK_SET: begin
                    // Lock bits only move toward programmed; pointer ignored
                    nxt_state.lock[5:2] = state_ff.lock[5:2] & state_ff.wdata[5:2];
                    nxt_state.cmd = 5'h00;
                    nxt_state.cnt = 3'h0;
                  end
                  `CMD_REENABLE: begin
                    nxt_state.busy = 1'b0;
                    nxt_state.cmd  = 5'h00;
                    nxt_state.cnt  = 3'h0;
                  end
                  default: begin
                    nxt_state.cmd = 5'h00;
                  end
                endcase
              end
            end else if (wb_sel_i[0] && wb_dat_i[`BIT_ISSUE_LOAD]) begin
              // Lock/fuse read needs the shorter window; fuses are read-only here
              if (state_ff.cmd == `CMD_LOCK_SET && state_ff.op == OP_IDLE &&
                  state_ff.cnt > (`STORE_WINDOW - `LOAD_WINDOW)) begin
                case (state_ff.zptr[1:0])
                  2'h0:    nxt_state.result = fuse_low_i;
                  2'h1:    nxt_state.result = state_ff.lock;
                  2'h2:    nxt_state.result = fuse_ext_i;
                  default: nxt_state.result = fuse_high_i;
                endcase
                nxt_state.cmd = 5'h00;
                nxt_state.cnt = 3'h0;
              end else begin
                nxt_state.raddr   = byte_addr;
                nxt_state.rd_pend = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (wb_adr_i)
          `REG_CTRL_STATUS:  nxt_state.rdat = {24'h0, state_ff.ie, state_ff.busy, 1'b0,
                                               state_ff.cmd};
          `REG_POINTER:      nxt_state.rdat = {16'h0, state_ff.zptr};
          `REG_PAGE_EXT:     nxt_state.rdat = {24'h0, state_ff.ext};
          `REG_STORE_DATA:   nxt_state.rdat = {16'h0, state_ff.wdata};
          `REG_LOAD_RESULT:  nxt_state.rdat = {24'h0, state_ff.result};
          `REG_ENGINE_STATE: nxt_state.rdat = {28'h0, state_ff.halt, state_ff.strm,
                                               (state_ff.op == OP_WRITE),
                                               (state_ff.op == OP_ERASE)};
          default:           nxt_state.rdat = 32'h0;
        endcase
      end
    end

    // Ready interrupt is a level that stays up while enabled, globally enabled and nothing is armed
    nxt_state.irq = nxt_state.ie & global_irq_enable_i &
                    ~nxt_state.cmd[`BIT_STORE_ARM];
  end

  // Single state register; the reset vector is sampled from the fuse while reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff       <= '0;
      state_ff.lock  <= `LOCK_RESET;
      state_ff.rvec  <= boot_reset_fuse_i ? `APP_RESET_VECTOR : BOOT_START;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Every output is a field of the state register
  assign wb_ack_o            = state_ff.ack;
  assign wb_dat_o            = state_ff.rdat;
  assign flash_raddr_o       = state_ff.raddr;
  assign flash_erase_o       = state_ff.erase_p;
  assign flash_we_o          = state_ff.we;
  assign flash_waddr_o       = state_ff.faddr;
  assign flash_wdata_o       = state_ff.fwdata;
  assign lock_bits_o         = state_ff.lock;
  assign section_busy_flag_o = state_ff.busy;
  assign cpu_halt_o          = state_ff.halt;
  assign store_ready_irq_o   = state_ff.irq;
  assign reset_vector_o      = state_ff.rvec;

endmodule

// [tb/self_program_flash_sva.sv]
// Checker for the self-program flash control, bound to its top module.
// Assumes it sees only top-level ports; parameters are handed down by the bind.
`timescale 1ns/1ps
module self_program_flash_sva #(
  parameter int          PAGE_WORDS      = 128,
  parameter int          PAGE_BITS       = 9,
  parameter int          HALTING_SECTION_FIRST_PAGE = 480,
  parameter logic [15:0] BOOT_START      = 16'hF000
) (
  input  wire logic                                    clk_i,
  input  wire logic                                    rst_i,
  input  wire logic                                    global_irq_enable_i,
  input  wire logic                                    boot_reset_fuse_i,
  input  wire logic                                    flash_erase_o,
  input  wire logic                                    flash_we_o,
  input  wire logic [PAGE_BITS+$clog2(PAGE_WORDS)-1:0] flash_waddr_o,
  input  wire logic [7:0]                              lock_bits_o,
  input  wire logic                                    section_busy_flag_o,
  input  wire logic                                    cpu_halt_o,
  input  wire logic                                    store_ready_irq_o,
  input  wire logic [15:0]                             reset_vector_o
);
  localparam int WB = $clog2(PAGE_WORDS);
  logic [15:0]          we_run_ff;
  logic [15:0]          nxt_we_run;
  logic [PAGE_BITS-1:0] page;

  // Run length of word strobes, so a short page stream is caught
  always_comb nxt_we_run = flash_we_o ? we_run_ff + 16'h1 : 16'h0;
  always_ff @(posedge clk_i) we_run_ff <= rst_i ? 16'h0 : nxt_we_run;
  assign page = flash_waddr_o[PAGE_BITS+WB-1:WB];

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  irq_gate_a: assert property (!$past(global_irq_enable_i) |-> !store_ready_irq_o)
    else $error("ready interrupt without global enable");
  busy_rww_a: assert property (flash_erase_o && page < HALTING_SECTION_FIRST_PAGE |->
    ##[0:1] (section_busy_flag_o && !cpu_halt_o)) else $error("erase left section open");
  busy_write_a: assert property ($rose(flash_we_o) && page < HALTING_SECTION_FIRST_PAGE |->
    section_busy_flag_o && !cpu_halt_o) else $error("write left section open");
  halt_halting_section_a: assert property (flash_erase_o && page >= HALTING_SECTION_FIRST_PAGE |->
    ##[0:1] cpu_halt_o) else $error("no halt for halting-section erase");
  halt_hold_a: assert property ($rose(cpu_halt_o) |-> cpu_halt_o[*8])
    else $error("halt dropped early");
  erase_word_a: assert property (flash_erase_o |-> flash_waddr_o[WB-1:0] == '0)
    else $error("erase address carries word bits");
  we_run_a: assert property ($fell(flash_we_o) |-> we_run_ff == 16'(PAGE_WORDS))
    else $error("page stream length wrong");
  page_hold_a: assert property (flash_we_o && $past(flash_we_o) |->
    page == $past(page)) else $error("page changed during write");
  lock_mono_a: assert property ((lock_bits_o & ~$past(lock_bits_o)) == 8'h00 &&
    lock_bits_o[7:6] == 2'b11 && lock_bits_o[1:0] == 2'b11) else $error("lock bits rose");
  reset_vec_a: assert property ($past(rst_i) |-> reset_vector_o ==
    ($past(boot_reset_fuse_i) ? 16'h0000 : BOOT_START)) else $error("reset vector wrong");
  vec_hold_a: assert property (!$past(rst_i) |-> $stable(reset_vector_o))
    else $error("reset vector moved outside reset");

  erase_rww_c: cover property (flash_erase_o && page < HALTING_SECTION_FIRST_PAGE);
  halt_c: cover property ($rose(cpu_halt_o));
  stream_c: cover property ($fell(flash_we_o));
endmodule

bind self_program_flash_control self_program_flash_sva #(.PAGE_WORDS(PAGE_WORDS),
  .PAGE_BITS(PAGE_BITS), .HALTING_SECTION_FIRST_PAGE(HALTING_SECTION_FIRST_PAGE), .BOOT_START(BOOT_START))
  u_sva (.clk_i, .rst_i, .global_irq_enable_i, .boot_reset_fuse_i, .flash_erase_o,
  .flash_we_o, .flash_waddr_o, .lock_bits_o, .section_busy_flag_o, .cpu_halt_o,
  .store_ready_irq_o, .reset_vector_o);

// [tb/flash_array_model.sv]
// Behavioural program flash array beside the control block.
// Assumes one erase pulse per page and one strobe per word; a read settles before the next edge.
`timescale 1ns/1ps
module flash_array_model #(
  parameter int PAGE_WORDS = 128
) (
  input  wire logic        clk_i,
  input  wire logic [16:0] raddr_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        erase_i,
  input  wire logic        we_i,
  input  wire logic [15:0] waddr_i,
  input  wire logic [15:0] wdata_i
);
  logic [15:0] mem [int];
  logic [15:0] word;

  initial rdata_o = 8'h00;
  // Programming only clears bits, so a write to an unerased page corrupts it
  always @(posedge clk_i) begin
    if (erase_i)
      for (int i = 0; i < PAGE_WORDS; i++) mem[int'(waddr_i) + i] = 16'hFFFF;
    if (we_i)
      mem[int'(waddr_i)] = wdata_i & (mem.exists(int'(waddr_i)) ? mem[int'(waddr_i)] : 16'hFFFF);
  end
  // Read byte follows the address within half a cycle, as the control captures it one edge on
  always @(negedge clk_i) begin
    word = mem.exists(int'(raddr_i >> 1)) ? mem[int'(raddr_i >> 1)] : 16'hFFFF;
    rdata_o <= raddr_i[0] ? word[15:8] : word[7:0];
  end
endmodule

// [tb/self_program_flash_control_tb.sv]
// Self-checking bench: drives the register bus as the CPU would, keeps a flash array
// beside the block and checks bus reads and flash traffic against queued notes.
// Assumes a shortened programming time; the waits for each erase or write to finish derive from it.
`timescale 1ns/1ps
`include "self_program_flash_defs.svh"
module self_program_flash_control_tb;
  localparam int          PROG = 200;
  localparam logic [15:0] BOOT = 16'hF000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, global_irq_enable_i, boot_reset_fuse_i;
  logic        flash_erase_o, flash_we_o, section_busy_flag_o, cpu_halt_o, store_ready_irq_o;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, fuse_low_i, fuse_high_i, fuse_ext_i, flash_rdata_i, lock_bits_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [16:0] flash_raddr_o;
  logic [15:0] flash_waddr_o, flash_wdata_o, reset_vector_o;
  logic [15:0] bufm [128];
  logic [31:0] rd_q [$];
  logic [32:0] fl_q [$];
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;

  self_program_flash_control #(.PROG_CYCLES(PROG), .BOOT_START(BOOT)) DUT (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .global_irq_enable_i, .boot_reset_fuse_i, .fuse_low_i,
    .fuse_high_i, .fuse_ext_i, .flash_rdata_i, .flash_raddr_o, .flash_erase_o, .flash_we_o,
    .flash_waddr_o, .flash_wdata_o, .lock_bits_o, .section_busy_flag_o, .cpu_halt_o,
    .store_ready_irq_o, .reset_vector_o);
  flash_array_model FLASH (.clk_i, .raddr_i(flash_raddr_o), .rdata_o(flash_rdata_i),
    .erase_i(flash_erase_o), .we_i(flash_we_o), .waddr_i(flash_waddr_o), .wdata_i(flash_wdata_o));

  always #4 clk_i = ~clk_i;

  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  // Classic cycle; the request stands until the rising edge that samples ack high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] want);
    rd_q.push_back(want);
    wb(1'b0, adr, 32'h0);
  endtask

  task automatic ptr(input logic [8:0] pg, input logic [6:0] w, input logic b);
    wb(1'b1, `REG_PAGE_EXT, {31'h0, pg[8]});
    wb(1'b1, `REG_POINTER, {16'h0, pg[7:0], w, b});
  endtask

  task automatic store_program_instruction(input logic [7:0] c, input logic [15:0] d, input int late);
    wb(1'b1, `REG_STORE_DATA, {16'h0, d});
    wb(1'b1, `REG_CTRL_STATUS, {24'h0, c});
    repeat (late) @(posedge clk_i);
    wb(1'b1, `REG_ISSUE, 32'h1);
  endtask

  task automatic fill(input logic [8:0] pg, input logic [6:0] w, input logic [15:0] d);
    ptr(pg, w, 1'b0);
    store_program_instruction(8'h01, d, 0);
    bufm[w] = d;
  endtask

  // Erase or write of a whole page; flash traffic is noted before it starts
  task automatic page_op(input logic [8:0] pg, input logic wr);
    ptr(pg, 7'h0, 1'b0);
    if (wr) for (int w = 0; w < 128; w++) fl_q.push_back({1'b0, pg, w[6:0], bufm[w]});
    else fl_q.push_back({1'b1, pg, 7'h0, 16'h0});
    store_program_instruction(wr ? 8'h05 : 8'h03, 16'($urandom), 0);
    @(negedge clk_i);
  endtask

  // Watcher: pairs every read answer and flash strobe with the oldest note
  always @(negedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
      check({1'b0, wb_dat_o}, {1'b0, rd_q.pop_front()});
    if (flash_we_o === 1'b1 || flash_erase_o === 1'b1)
      check({flash_erase_o, flash_waddr_o, flash_erase_o ? 16'h0 : flash_wdata_o},
            fl_q.size() > 0 ? fl_q.pop_front() : 33'h1FFFFFFFF);
  end

  initial begin
    logic [7:0]  r0, lexp;
    logic [6:0]  w0;
    logic [15:0] d0;
    logic [4:0]  c;
    void'($urandom(32'h5A4A));
    {wb_cyc_i, wb_stb_i, wb_we_i, global_irq_enable_i, boot_reset_fuse_i} = 5'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    fuse_low_i = 8'($urandom);
    fuse_high_i = 8'($urandom);
    fuse_ext_i = 8'($urandom);
    bufm = '{default: 16'h0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check(33'(reset_vector_o), 33'(BOOT));
    check(33'(lock_bits_o), 33'h0FF);
    rd(`REG_CTRL_STATUS, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = 5'($urandom);
      if (c inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}) c = 5'h1F;
      wb(1'b1, `REG_CTRL_STATUS, {27'h0, c});
      rd(`REG_CTRL_STATUS, 32'h0);
    end
    @(posedge clk_i);
    global_irq_enable_i <= 1'b1;
    wb(1'b1, `REG_CTRL_STATUS, 32'h80);
    repeat (2) @(negedge clk_i);
    check(33'(store_ready_irq_o), 33'h1);
    wb(1'b1, `REG_CTRL_STATUS, 32'h81);
    @(negedge clk_i);
    check(33'(store_ready_irq_o), 33'h0);
    repeat (2) @(negedge clk_i);
    check(33'(store_ready_irq_o), 33'h0);
    @(negedge clk_i);
    check(33'(store_ready_irq_o), 33'h1);
    @(posedge clk_i);
    global_irq_enable_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    check(33'(store_ready_irq_o), 33'h0);
    wb(1'b1, `REG_CTRL_STATUS, 32'h0);
    r0 = 8'($urandom);
    lexp = {2'b11, r0[5:2], 2'b11};
    store_program_instruction(8'h09, {8'hFF, r0}, 0);
    repeat (8) @(negedge clk_i);
    check(33'(lock_bits_o), 33'(lexp));
    for (int z = 0; z < 4; z++) begin
      wb(1'b1, `REG_POINTER, 32'(z));
      wb(1'b1, `REG_CTRL_STATUS, 32'h09);
      wb(1'b1, `REG_ISSUE, 32'h2);
      rd(`REG_LOAD_RESULT, {24'h0, z == 0 ? fuse_low_i : z == 1 ? lexp :
                                   z == 2 ? fuse_ext_i : fuse_high_i});
    end
    page_op(9'd2, 1'b0);
    check(33'(cpu_halt_o), 33'h0);
    rd(`REG_CTRL_STATUS, 32'h43);
    wb(1'b1, `REG_CTRL_STATUS, 32'h11);
    rd(`REG_CTRL_STATUS, 32'h43);
    repeat (PROG) @(posedge clk_i);
    rd(`REG_CTRL_STATUS, 32'h40);
    store_program_instruction(8'h11, 16'h0, 0);
    rd(`REG_CTRL_STATUS, 32'h00);
    w0 = 7'($urandom);
    for (int i = 0; i < 4; i++) fill(9'd2, w0 - 7'(i * 37), 16'($urandom));
    ptr(9'd2, w0 + 7'd1, 1'b0);
    store_program_instruction(8'h01, 16'h1234, 2);
    page_op(9'd2, 1'b1);
    ptr(9'd7, 7'd3, 1'b0);
    rd(`REG_CTRL_STATUS, 32'h45);
    repeat (PROG) @(posedge clk_i);
    d0 = bufm[w0];
    bufm = '{default: 16'h0};
    fill(9'd7, 7'd9, 16'hBEEF);
    rd(`REG_CTRL_STATUS, 32'h00);
    wb(1'b1, `REG_CTRL_STATUS, 32'h11);
    bufm = '{default: 16'h0};
    page_op(9'd480, 1'b0);
    check(33'(cpu_halt_o), 33'h1);
    check(33'(section_busy_flag_o), 33'h0);
    repeat (PROG) @(posedge clk_i);
    @(negedge clk_i);
    check(33'(cpu_halt_o), 33'h0);
    page_op(9'd480, 1'b1);
    repeat (PROG) @(posedge clk_i);
    ptr(9'd2, w0, 1'b1);
    wb(1'b1, `REG_ISSUE, 32'h2);
    repeat (2) @(negedge clk_i);
    check(33'(flash_raddr_o), {16'h0, 9'd2, w0, 1'b1});
    rd(`REG_LOAD_RESULT, {24'h0, d0[15:8]});
    @(posedge clk_i);
    boot_reset_fuse_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check(33'(reset_vector_o), 33'h0);
    repeat (4) @(posedge clk_i);
    check(33'(fl_q.size() + rd_q.size()), 33'h0);
    report_and_stop();
  end
endmodule
